//--- rtl/bpmu_consts.vh
// constants for the breakpoint match unit: offsets, fields, resets
// assumes a 32-bit register port with word-aligned byte offsets
`ifndef BPMU_CONSTS_VH
`define BPMU_CONSTS_VH

// register byte offsets
`define BPMU_OFS_ADDR0    8'h00
`define BPMU_OFS_ADDR1    8'h04
`define BPMU_OFS_ADDR2    8'h08
`define BPMU_OFS_ADDR3    8'h0C
`define BPMU_OFS_STATUS   8'h18
`define BPMU_OFS_CTRL     8'h1C
`define BPMU_OFS_IRQ_STAT 8'h20
`define BPMU_OFS_IRQ_EN   8'h24
`define BPMU_OFS_IRQ_CLR  8'h28

// control register fields
`define BPMU_CTL_LOC_EN0  0
`define BPMU_CTL_GLB_EN0  1
`define BPMU_CTL_PTASK    8
`define BPMU_CTL_PERSIST  9
`define BPMU_CTL_GUARD    13
`define BPMU_CTL_USAGE0   16
`define BPMU_CTL_SIZE0    18
`define BPMU_CTL_MASK     32'hFFFF_23FF
`define BPMU_CTL_RESET    32'h0000_0000

// status register fields
`define BPMU_STS_GUARD    13
`define BPMU_STS_MASK     32'h0000_200F
`define BPMU_STS_RESET    32'h0000_0000

// encodings
`define BPMU_USE_EXEC     2'h0
`define BPMU_USE_WRITE    2'h1
`define BPMU_USE_RDWR     2'h3
`define BPMU_SIZE_BYTE    2'h0
`define BPMU_SIZE_WORD    2'h1
`define BPMU_SIZE_DWORD   2'h3

// interrupt event bits
`define BPMU_EV_FAULT     0
`define BPMU_EV_TRAP      1
`define BPMU_EV_GUARD     2
`define BPMU_EV_NUM       3

`endif

//--- rtl/bpmu_cmp.v
// one breakpoint comparator: aligned region against one access
// assumes an access never crosses a dword boundary
`timescale 1ns/1ps
`default_nettype none
`include "bpmu_consts.vh"
module bpmu_cmp (
   input  wire [31:0] bp_addr,   // breakpoint linear address
   input  wire [1:0]  bp_size,   // region size code
   input  wire [31:0] acc_addr,  // access linear address
   input  wire [1:0]  acc_len,   // access length code, same codes
   output wire        hit        // region and access overlap
);
   // byte lanes touched inside the dword
   function [3:0] lanes;
      input [1:0] a;
      input [1:0] len;
      reg   [3:0] m;
      begin
         case (len)
            `BPMU_SIZE_BYTE:  m = 4'h1;
            `BPMU_SIZE_WORD:  m = 4'h3;
            `BPMU_SIZE_DWORD: m = 4'hF;
            default:          m = 4'h0;
         endcase
         lanes = m << a;
      end
   endfunction

   wire [3:0] bp_lanes;  // low bits ignored by size force alignment
   wire [3:0] acc_lanes; // lanes of the access itself
   wire [1:0] bp_base;   // aligned start of the watched region

   assign bp_base   = (bp_size == `BPMU_SIZE_DWORD) ? 2'h0 :
                      (bp_size == `BPMU_SIZE_WORD) ?
                      {bp_addr[1], 1'b0} : bp_addr[1:0];
   assign bp_lanes  = lanes(bp_base, bp_size);
   assign acc_lanes = lanes(acc_addr[1:0], acc_len);
   // overlap of lanes gives exact matching
   assign hit = (bp_addr[31:2] == acc_addr[31:2]) &&
                ((bp_lanes & acc_lanes) != 4'h0);
endmodule
`default_nettype wire

//--- rtl/bpmu_irq.v
// sticky event flags, enable mask, write-one clear, level output
// assumes events and clears are pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module bpmu_irq #(
   parameter W = 3                  // number of events
) (
   input  wire         clk_sys,     // core clock
   input  wire         arst_n,      // asynchronous reset, low
   input  wire [W-1:0] ev,          // event pulses
   input  wire         en_we,       // enable register write
   input  wire [W-1:0] en_wdata,    // new enable mask
   input  wire         clr_we,      // clear register write
   input  wire [W-1:0] clr_wdata,   // ones clear flags
   output reg  [W-1:0] stat_q,      // sticky flags
   output reg  [W-1:0] en_q,        // enable mask
   output reg          irq_q        // level interrupt
);
   reg [W-1:0] stat_d; // next flags

   // set wins over a clear in the same cycle
   always @* begin
      stat_d = stat_q;
      if (clr_we) begin
         stat_d = stat_d & ~clr_wdata;
      end
      stat_d = stat_d | ev;
   end

   // flags, mask and the registered output
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stat_q <= {W{1'b0}};
         en_q   <= {W{1'b0}};
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (en_we) begin
            en_q <= en_wdata;
         end
         irq_q <= |(stat_d & (en_we ? en_wdata : en_q));
      end
   end
endmodule
`default_nettype wire

//--- rtl/bpmu_top.v
// breakpoint match unit: four address breakpoints, control, status
// assumes the core presents fetch and data accesses on clk_sys and
// pulses instr_done when an instruction with its operands retires
`timescale 1ns/1ps
`default_nettype none
`include "bpmu_consts.vh"
module bpmu_top #(
   parameter NBP = 4                     // number of breakpoints
) (
   input  wire        clk_sys,           // core clock, 100 MHz
   input  wire        arst_n,            // asynchronous reset, low
   // register port
   input  wire [7:0]  reg_addr,          // byte offset
   input  wire [31:0] reg_wdata,         // write data
   input  wire        reg_wr,            // write strobe
   input  wire        reg_rd,            // read strobe
   output reg  [31:0] reg_rdata_q,       // read data, next cycle
   // privilege of the requesting code
   input  wire        cpu_real_mode,     // core in real mode
   input  wire [1:0]  cpu_cpl,           // current privilege level
   // core activity
   input  wire        ifetch_vld,        // instruction about to run
   input  wire [31:0] ifetch_addr,       // its first byte, linear
   input  wire        dacc_vld,          // operand transfer done
   input  wire [31:0] dacc_addr,         // operand linear address
   input  wire [1:0]  dacc_len,          // operand length code
   input  wire        dacc_wr,           // transfer is a write
   input  wire        instr_done,        // instruction completed
   input  wire        task_switch,       // task switch pulse
   // results
   output reg         dbg_fault_q,       // exception 1 fault pulse
   output reg         dbg_trap_q,        // exception 1 trap pulse
   output reg         guard_fault_q,     // guard-refused access pulse
   output reg         exact_hold_q,      // serialise operands level
   output reg         reg_refused_q,     // access refused, one-cycle pulse
   output wire        irq                // interrupt level, from flop
);

   // software-visible state
   reg [31:0] bp_addr_reg_q [0:NBP-1];   // breakpoint addresses
   reg [31:0] ctrl_q;                    // breakpoint_control
   reg [31:0] ctrl_d;                    // its next value
   reg [31:0] status_q;                  // breakpoint_status
   reg [31:0] status_d;                  // its next value

   // held data hits waiting for the instruction to finish
   reg [NBP-1:0] pend_q;                 // pending data hits
   reg [NBP-1:0] pend_d;                 // next pending set

   // per-breakpoint decoded controls
   wire [NBP-1:0] bp_armed;              // global or local enable
   wire [NBP-1:0] exec_hit;              // execute breakpoint hits
   wire [NBP-1:0] data_hit;              // data breakpoint hits
   wire [NBP-1:0] data_kind;             // armed as a data watch

   // register port decode
   wire allowed;      // privilege allows access
   wire guard_on;     // access trap bit set
   wire reg_acc;      // any strobe
   wire reg_ok;       // strobe that is carried out
   wire wr_ok;        // accepted write
   wire rd_ok;        // accepted read
   wire refuse;       // strobe refused
   wire ev_fault;     // fault event this cycle
   wire ev_trap;      // trap event this cycle
   wire [`BPMU_EV_NUM-1:0] irq_stat;     // sticky interrupt flags
   wire [`BPMU_EV_NUM-1:0] irq_en;       // interrupt enables

   // privilege check then guard bit; guard beats level 0 too
   assign guard_on = ctrl_q[`BPMU_CTL_GUARD];
   assign allowed  = cpu_real_mode || (cpu_cpl == 2'h0);
   assign reg_acc  = reg_wr || reg_rd;
   assign reg_ok   = reg_acc && allowed && !guard_on;
   assign refuse   = reg_acc && !reg_ok;
   assign wr_ok    = reg_wr && reg_ok;
   assign rd_ok    = reg_rd && reg_ok;

   // one comparator pair per breakpoint
   genvar gi;
   generate
      for (gi = 0; gi < NBP; gi = gi + 1) begin : g_bp
         wire [1:0] use_f;   // usage field
         wire [1:0] size_f;  // size field
         wire       f_hit;   // fetch address match
         wire       d_hit;   // operand address match
         wire       wr_ok_f; // usage accepts this direction
         assign use_f  = ctrl_q[`BPMU_CTL_USAGE0 + 4*gi +: 2];
         assign size_f = ctrl_q[`BPMU_CTL_SIZE0 + 4*gi +: 2];
         // either enable arms it; reset clears both
         assign bp_armed[gi] = ctrl_q[`BPMU_CTL_LOC_EN0 + 2*gi] ||
                               ctrl_q[`BPMU_CTL_GLB_EN0 + 2*gi];
         // instruction fetch compared as a single byte
         bpmu_cmp u_fcmp (
            .bp_addr  (bp_addr_reg_q[gi]),
            .bp_size  (size_f),
            .acc_addr (ifetch_addr),
            .acc_len  (`BPMU_SIZE_BYTE),
            .hit      (f_hit)
         );
         // operand compared over its full length
         bpmu_cmp u_dcmp (
            .bp_addr  (bp_addr_reg_q[gi]),
            .bp_size  (size_f),
            .acc_addr (dacc_addr),
            .acc_len  (dacc_len),
            .hit      (d_hit)
         );
         // usage 01 watches writes, 11 both, 10 never
         assign wr_ok_f = (use_f == `BPMU_USE_RDWR) ||
                          ((use_f == `BPMU_USE_WRITE) && dacc_wr);
         // usage 00 with any size code except 10 matches the fetch byte
         assign exec_hit[gi] = ifetch_vld && bp_armed[gi] &&
                               (use_f == `BPMU_USE_EXEC) &&
                               (size_f != 2'h2) && f_hit;
         assign data_hit[gi] = dacc_vld && bp_armed[gi] &&
                               wr_ok_f && (size_f != 2'h2) && d_hit;
         assign data_kind[gi] = bp_armed[gi] &&
                                ((use_f == `BPMU_USE_WRITE) ||
                                 (use_f == `BPMU_USE_RDWR));
      end
   endgenerate

   // execute hits raise the fault at once, exact bits ignored
   assign ev_fault = |exec_hit;
   // held data hits are reported when the instruction retires
   assign ev_trap  = instr_done && (|pend_d);

   // pending data hits accumulate over the instruction
   always @* begin
      pend_d = pend_q | data_hit;
   end

   // control register next value
   always @* begin
      ctrl_d = ctrl_q;
      if (wr_ok && (reg_addr == `BPMU_OFS_CTRL)) begin
         ctrl_d = reg_wdata & `BPMU_CTL_MASK;
      end
      // task switch drops only the per-task exact bit
      if (task_switch) begin
         ctrl_d[`BPMU_CTL_PTASK] = 1'b0;
      end
      // persistent exact bit is left alone
      // a refused access disarms the guard so the handler can get in
      if (refuse && guard_on) begin
         ctrl_d[`BPMU_CTL_GUARD] = 1'b0;
      end
   end

   // status register: software writes, hardware sets win
   always @* begin
      status_d = status_q;
      if (wr_ok && (reg_addr == `BPMU_OFS_STATUS)) begin
         status_d = reg_wdata & `BPMU_STS_MASK;
      end
      // one flag per breakpoint cause
      if (ev_fault) begin
         status_d[NBP-1:0] = status_d[NBP-1:0] | exec_hit;
      end
      if (ev_trap) begin
         status_d[NBP-1:0] = status_d[NBP-1:0] | pend_d;
      end
      if (refuse && guard_on) begin
         status_d[`BPMU_STS_GUARD] = 1'b1;
      end
   end

   // breakpoint address registers
   integer k;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < NBP; k = k + 1) begin
            bp_addr_reg_q[k] <= 32'h0000_0000;
         end
      end else if (wr_ok && (reg_addr[7:4] == 4'h0) &&
                   (reg_addr[1:0] == 2'h0)) begin
         // offsets 00..0C map to index by bits 3:2; odd ones unmapped
         bp_addr_reg_q[reg_addr[3:2]] <= reg_wdata;
      end
   end

   // control, status, pending hits
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q   <= `BPMU_CTL_RESET;
         status_q <= `BPMU_STS_RESET;
         pend_q   <= {NBP{1'b0}};
      end else begin
         ctrl_q   <= ctrl_d;
         status_q <= status_d;
         // retire empties the held set; a hit at retire is in it
         if (instr_done) begin
            pend_q <= {NBP{1'b0}};
         end else begin
            pend_q <= pend_d;
         end
      end
   end

   // event outputs from flops; all but exact_hold_q are one-cycle pulses
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dbg_fault_q   <= 1'b0;
         dbg_trap_q    <= 1'b0;
         guard_fault_q <= 1'b0;
         reg_refused_q <= 1'b0;
         exact_hold_q  <= 1'b0;
      end else begin
         dbg_fault_q   <= ev_fault;
         dbg_trap_q    <= ev_trap;
         guard_fault_q <= refuse && guard_on;
         reg_refused_q <= refuse;
         // any armed data watch asks the core to finish operands
         // before starting the next instruction; costs speed only
         // while data watches are armed
         exact_hold_q  <= |data_kind;
      end
   end

   // read mux; refused or unmapped reads return zero
   reg [31:0] rd_mux; // selected read value
   always @* begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         `BPMU_OFS_ADDR0:    rd_mux = bp_addr_reg_q[0];
         `BPMU_OFS_ADDR1:    rd_mux = bp_addr_reg_q[1];
         `BPMU_OFS_ADDR2:    rd_mux = bp_addr_reg_q[2];
         `BPMU_OFS_ADDR3:    rd_mux = bp_addr_reg_q[3];
         `BPMU_OFS_STATUS:   rd_mux = status_q;
         `BPMU_OFS_CTRL:     rd_mux = ctrl_q;
         `BPMU_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat};
         `BPMU_OFS_IRQ_EN:   rd_mux = {29'h0, irq_en};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else if (rd_ok) begin
         reg_rdata_q <= rd_mux;
      end else begin
         reg_rdata_q <= 32'h0000_0000;
      end
   end

   // interrupt flags: fault, trap, guard refusal
   bpmu_irq #(
      .W (`BPMU_EV_NUM)
   ) u_irq (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .ev        ({refuse && guard_on, ev_trap, ev_fault}),
      .en_we     (wr_ok && (reg_addr == `BPMU_OFS_IRQ_EN)),
      .en_wdata  (reg_wdata[`BPMU_EV_NUM-1:0]),
      .clr_we    (wr_ok && (reg_addr == `BPMU_OFS_IRQ_CLR)),
      .clr_wdata (reg_wdata[`BPMU_EV_NUM-1:0]),
      .stat_q    (irq_stat),
      .en_q      (irq_en),
      .irq_q     (irq)
   );
endmodule
`default_nettype wire

//--- verif/bpmu_top_asserts.sv
// checker for the breakpoint match unit, watching bpmu_top ports only
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module bpmu_chk (
   input wire logic        clk_sys,       // core clock
   input wire logic        arst_n,        // async reset, low
   input wire logic [7:0]  reg_addr,      // byte offset
   input wire logic [31:0] reg_wdata,     // write data
   input wire logic        reg_wr,        // write strobe
   input wire logic        reg_rd,        // read strobe
   input wire logic [31:0] reg_rdata_q,   // read data
   input wire logic        cpu_real_mode, // real mode
   input wire logic [1:0]  cpu_cpl,       // privilege level
   input wire logic        ifetch_vld,    // fetch pulse
   input wire logic [31:0] ifetch_addr,   // fetch address
   input wire logic        dacc_vld,      // operand pulse
   input wire logic [31:0] dacc_addr,     // operand address
   input wire logic [1:0]  dacc_len,      // operand length
   input wire logic        dacc_wr,       // operand is write
   input wire logic        instr_done,    // retire pulse
   input wire logic        task_switch,   // task switch pulse
   input wire logic        dbg_fault_q,   // fault pulse
   input wire logic        dbg_trap_q,    // trap pulse
   input wire logic        guard_fault_q, // guard refusal
   input wire logic        exact_hold_q,  // serialise level
   input wire logic        reg_refused_q, // refusal pulse
   input wire logic        irq            // interrupt level
);
   logic wr_seen_q;                       // a write since reset
   wire  low_priv = !cpu_real_mode && (cpu_cpl != 2'h0); // no access
   // no breakpoint fault, trap or hold may fire before software has written anything
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) wr_seen_q <= 1'b0;
      else if (reg_wr) wr_seen_q <= 1'b1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   rd_idle_zero_a: assert property (
      !$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data not zero outside read answer");
   priv_refuse_a: assert property (
      low_priv && (reg_rd || reg_wr) |=> reg_refused_q)
      else $error("low privilege access not refused");
   priv_rd_zero_a: assert property (
      low_priv && reg_rd |=> reg_rdata_q == 32'h0)
      else $error("refused read gave data");
   fault_cause_a: assert property (
      dbg_fault_q |-> $past(ifetch_vld))
      else $error("fault without a fetch one cycle before");
   trap_cause_a: assert property (
      dbg_trap_q |-> $past(instr_done))
      else $error("trap not one cycle after retire");
   guard_refuse_a: assert property (
      guard_fault_q |-> reg_refused_q)
      else $error("guard refusal without refusal pulse");
   refuse_cause_a: assert property (
      reg_refused_q |-> $past(reg_rd || reg_wr))
      else $error("refusal without a strobe");
   reset_quiet_a: assert property (
      !wr_seen_q |-> !dbg_fault_q && !dbg_trap_q && !exact_hold_q)
      else $error("breakpoint active before any write");
endmodule
`default_nettype wire

//--- verif/bpmu_core_model.sv
// core execution unit model: fetches, operand transfers, retire
// assumes the caller sits in the bench; signals change after edges
`timescale 1ns/1ps
`default_nettype none
module bpmu_core_model (
   input  wire logic   clk_sys,      // core clock
   output logic        ifetch_vld,   // fetch pulse
   output logic [31:0] ifetch_addr,  // fetch address
   output logic        dacc_vld,     // operand pulse
   output logic [31:0] dacc_addr,    // operand address
   output logic [1:0]  dacc_len,     // operand length
   output logic        dacc_wr,      // operand is write
   output logic        instr_done,   // retire pulse
   output logic        task_switch   // task switch pulse
);
   // idle state; stale addresses are inverted, never held
   initial begin
      {ifetch_vld, dacc_vld, dacc_wr, instr_done, task_switch} = 5'h00;
      {ifetch_addr, dacc_addr, dacc_len} = 66'h0;
   end
   // instruction about to run, first byte at a
   task automatic fetch(input logic [31:0] a);
      @(posedge clk_sys);
      ifetch_vld  <= 1'b1;
      ifetch_addr <= a;
      @(posedge clk_sys);
      ifetch_vld  <= 1'b0;
      ifetch_addr <= ~a;
   endtask
   // one operand transfer, never crossing a dword
   task automatic operand(input logic [31:0] a, input logic [1:0] l,
                          input logic w);
      @(posedge clk_sys);
      dacc_vld  <= 1'b1;
      dacc_addr <= a;
      dacc_len  <= l;
      dacc_wr   <= w;
      @(posedge clk_sys);
      dacc_vld  <= 1'b0;
      dacc_addr <= ~a;
      dacc_wr   <= ~w;
   endtask
   // retire only once all operands are done, called after them
   task automatic retire();
      @(posedge clk_sys);
      instr_done <= 1'b1;
      @(posedge clk_sys);
      instr_done <= 1'b0;
   endtask
   // one task switch pulse
   task automatic tswitch();
      @(posedge clk_sys);
      task_switch <= 1'b1;
      @(posedge clk_sys);
      task_switch <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verif/bpmu_bench.sv
// self-checking bench for bpmu_top with a core model beside it
// assumes the register offsets and fields of bpmu_consts.vh
`timescale 1ns/1ps
`default_nettype none
`include "bpmu_consts.vh"
module bpmu_bench;
   logic        clk_sys = 1'b0, arst_n = 1'b0; // clock and reset
   logic [7:0]  reg_addr = 8'h00;              // register offset
   logic [31:0] reg_wdata = 32'h0;             // write data
   logic        reg_wr = 1'b0, reg_rd = 1'b0;  // strobes
   logic        cpu_real_mode = 1'b0;          // real mode
   logic [1:0]  cpu_cpl = 2'h0;                // privilege level
   logic        ifetch_vld, dacc_vld, dacc_wr, instr_done, task_switch;
   logic [31:0] ifetch_addr, dacc_addr, reg_rdata_q;
   logic [1:0]  dacc_len;                      // operand length
   logic        dbg_fault_q, dbg_trap_q, guard_fault_q, exact_hold_q;
   logic        reg_refused_q, irq;            // refusal, interrupt
   int          num_errors = 0, n_tests = 0;   // counters
   always #5 clk_sys = ~clk_sys;
   bpmu_top bpmu_top_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .cpu_real_mode(cpu_real_mode), .cpu_cpl(cpu_cpl),
      .ifetch_vld(ifetch_vld), .ifetch_addr(ifetch_addr),
      .dacc_vld(dacc_vld), .dacc_addr(dacc_addr), .dacc_len(dacc_len),
      .dacc_wr(dacc_wr), .instr_done(instr_done),
      .task_switch(task_switch), .dbg_fault_q(dbg_fault_q),
      .dbg_trap_q(dbg_trap_q), .guard_fault_q(guard_fault_q),
      .exact_hold_q(exact_hold_q), .reg_refused_q(reg_refused_q),
      .irq(irq));
   bpmu_core_model core_i (.clk_sys(clk_sys), .ifetch_vld(ifetch_vld),
      .ifetch_addr(ifetch_addr), .dacc_vld(dacc_vld),
      .dacc_addr(dacc_addr), .dacc_len(dacc_len), .dacc_wr(dacc_wr),
      .instr_done(instr_done), .task_switch(task_switch));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // read data is taken in the one cycle it stands
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // expected overlap of an aligned region and an operand
   function automatic logic hit_exp(input logic [31:0] bp,
      input logic [1:0] sz, input logic [31:0] a, input logic [1:0] ln);
      logic [31:0] n, m, b;
      n = (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
      m = (ln == 2'h0) ? 1 : (ln == 2'h1) ? 2 : 4;
      b = bp & ~(n - 1);
      return (a < b + n) && (b < a + m);
   endfunction
   // watchdog, far beyond the expected run
   initial begin
      #400000;
      num_errors++;
      end_sim();
   end
   initial begin
      logic [31:0] d, a;
      logic [1:0]  sz, us, ln;
      logic        w, e;
      d = $urandom(87);
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(`BPMU_OFS_CTRL, d);
      check(d, `BPMU_CTL_RESET);
      rd(`BPMU_OFS_STATUS, d);
      check(d, `BPMU_STS_RESET);
      rd(8'h10, d);
      check(d, 32'h0);
      @(posedge clk_sys);
      cpu_cpl <= 2'h3;
      wr(`BPMU_OFS_ADDR0, 32'h0000_1234);
      #1 check(reg_refused_q, 1);
      @(posedge clk_sys);
      cpu_real_mode <= 1'b1;
      // the refused write must have left address 0 untouched
      rd(`BPMU_OFS_ADDR0, d);
      check(d, 32'h0);
      wr(`BPMU_OFS_ADDR0, 32'h0000_2000);
      cpu_real_mode <= 1'b0;
      cpu_cpl <= 2'h0;
      rd(`BPMU_OFS_ADDR0, d);
      check(d, 32'h0000_2000);
      wr(`BPMU_OFS_IRQ_EN, 32'h7);
      // instruction breakpoint 0: usage 00, size 00, local enable
      wr(`BPMU_OFS_CTRL, 32'h1);
      core_i.fetch(32'h2001);
      #1 check(dbg_fault_q, 0);
      core_i.fetch(32'h2000);
      #1 check(dbg_fault_q, 1);
      rd(`BPMU_OFS_STATUS, d);
      check(d, 32'h1);
      check(irq, 1);
      wr(`BPMU_OFS_IRQ_CLR, 32'h7);
      @(posedge clk_sys);
      #1 check(irq, 0);
      wr(`BPMU_OFS_IRQ_EN, 32'h0);
      core_i.fetch(32'h2000);
      repeat (2) @(posedge clk_sys);
      #1 check(irq, 0);
      wr(`BPMU_OFS_IRQ_CLR, 32'h7);
      wr(`BPMU_OFS_IRQ_EN, 32'h7);
      wr(`BPMU_OFS_CTRL, 32'h2);
      core_i.fetch(32'h2000);
      #1 check(dbg_fault_q, 1);
      wr(`BPMU_OFS_CTRL, 32'h0);
      core_i.fetch(32'h2000);
      #1 check(dbg_fault_q, 0);
      // random operands against data breakpoint 2 at every legal data size/usage
      wr(`BPMU_OFS_ADDR2, 32'h0000_1005);
      for (int i = 0; i < 48; i++) begin
         sz = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
         us = (i % 2) ? 2'h3 : 2'h1;
         ln = ($urandom % 3 == 2) ? 2'h3 : 2'($urandom % 2);
         a = 32'h1000 + ($urandom % 16);
         if (ln == 2'h1) a[0] = 1'b0;
         if (ln == 2'h3) a[1:0] = 2'h0;
         w = 1'($urandom % 2);
         // legal data setup: usage 01 or 11, size 00, 01 or 11
         wr(`BPMU_OFS_CTRL, 32'h10 | (32'(us) << 24) |
            (32'(sz) << 26));
         core_i.operand(a, ln, w);
         #1 check(dbg_trap_q, 0);
         check(exact_hold_q, 1);
         core_i.retire();
         e = hit_exp(32'h1005, sz, a, ln) && (w || us == 2'h3);
         #1 check(dbg_trap_q, e);
      end
      wr(`BPMU_OFS_STATUS, 32'h0);
      wr(`BPMU_OFS_CTRL, 32'h10 | (32'h2 << 24));
      core_i.operand(32'h1005, 2'h0, 1'b1);
      core_i.retire();
      #1 check(dbg_trap_q, 0);
      wr(`BPMU_OFS_CTRL, 32'h10 | (32'h3 << 24) | (32'h3 << 26));
      core_i.operand(32'h1006, 2'h0, 1'b0);
      core_i.retire();
      #1 check(dbg_trap_q, 1);
      rd(`BPMU_OFS_STATUS, d);
      check(d, 32'h4);
      wr(`BPMU_OFS_CTRL, 32'h300);
      core_i.tswitch();
      rd(`BPMU_OFS_CTRL, d);
      check(d, 32'h200);
      check(exact_hold_q, 0);
      wr(`BPMU_OFS_STATUS, 32'h0);
      // start the guard case with no interrupt flag left over
      wr(`BPMU_OFS_IRQ_CLR, 32'h7);
      #1 check(irq, 0);
      wr(`BPMU_OFS_CTRL, 32'h2000);
      rd(`BPMU_OFS_CTRL, d);
      check(d, 32'h0);
      check(guard_fault_q, 1);
      check(reg_refused_q, 1);
      rd(`BPMU_OFS_STATUS, d);
      check(d, 32'h2000);
      check(irq, 1);
      end_sim();
   end
endmodule
bind bpmu_top bpmu_chk bpmu_chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .cpu_real_mode(cpu_real_mode), .cpu_cpl(cpu_cpl),
   .ifetch_vld(ifetch_vld), .ifetch_addr(ifetch_addr),
   .dacc_vld(dacc_vld), .dacc_addr(dacc_addr), .dacc_len(dacc_len),
   .dacc_wr(dacc_wr), .instr_done(instr_done), .task_switch(task_switch),
   .dbg_fault_q(dbg_fault_q), .dbg_trap_q(dbg_trap_q),
   .guard_fault_q(guard_fault_q), .exact_hold_q(exact_hold_q),
   .reg_refused_q(reg_refused_q), .irq(irq));
`default_nettype wire
